// *** logic/lmf_params.svh ***
`ifndef LMF_PARAMS_SVH
`define LMF_PARAMS_SVH
// ----------------------------------------
// link and register map of the driver
// ----------------------------------------
`define LMF_DEV_ADDR    7'h34
`define LMF_A_PWM0      8'h01
`define LMF_PWM_DOTS    8'h48
`define LMF_A_CFG       8'hA0
`define LMF_A_GCL       8'hA1
`define LMF_A_PULL      8'hB0
`define LMF_A_RES0      8'hB3
`define LMF_A_RES_LAST  8'hC4
`define LMF_A_RST       8'hCF
`define LMF_RST_KEY     8'hAE
`define LMF_REG_DEF     8'h00
`define LMF_CFG_SSD     0
`define LMF_CFG_OS_HI   2
`define LMF_CFG_OS_LO   1
`define LMF_OS_NONE     2'h0
`define LMF_OS_OPEN     2'h1
`define LMF_OS_SHORT    2'h2
`define LMF_PULL_ROW_HI 7
`define LMF_PULL_ROW_LO 4
`define LMF_PULL_COL_HI 3
`define LMF_PULL_COL_LO 0
`define LMF_ROWS        9
`define LMF_COLS        8
`define LMF_BIT_ACK     4'h8
`define LMF_BIT_END     4'h9
// ----------------------------------------
// timing
// ----------------------------------------
`define LMF_CLK_NS      10
`define LMF_ROW_NS      30000
`define LMF_STEP_CYC    ((`LMF_ROW_NS / `LMF_CLK_NS) / 256)
`define LMF_SCL_NS      1000
`define LMF_QTR_CYC     ((`LMF_SCL_NS / `LMF_CLK_NS) / 4)
`define LMF_FRAME_BITS  27
// ----------------------------------------
// controller apb map
// ----------------------------------------
`define LMF_H_CMD       8'h00
`define LMF_H_STAT      8'h04
`define LMF_H_IST       8'h08
`define LMF_H_IMSK      8'h0C
`define LMF_H_CTRL      8'h10
`define LMF_CMD_RD      16
`endif

// *** logic/lmf_pkg.sv ***
`default_nettype none
package lmf_pkg;
  typedef enum logic [2:0] {
    LMF_S_IDLE  = 3'b000,
    LMF_S_ADDR  = 3'b001,
    LMF_S_REG   = 3'b010,
    LMF_S_WDATA = 3'b011,
    LMF_S_RDATA = 3'b100,
    LMF_S_DONE  = 3'b101
  } lmf_slv_t;
  typedef enum logic [1:0] {
    LMF_M_IDLE  = 2'b00,
    LMF_M_START = 2'b01,
    LMF_M_BITS  = 2'b10,
    LMF_M_STOP  = 2'b11
  } lmf_mst_t;
endpackage
`default_nettype wire

// *** logic/lmf_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface lmf_link_if;
  logic scl;
  logic pdn_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda;
  // open drain with pull-up: a released end reads as one
  assign sda = (sda_dev_oe_n | sda_dev_o) & (sda_host_oe_n | sda_host_o);
  modport dev (input scl, pdn_n, sda, output sda_dev_o, sda_dev_oe_n);
  modport host (input sda, output scl, pdn_n, sda_host_o, sda_host_oe_n);
endinterface
`default_nettype wire

// *** logic/lmf_device.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lmf_params.svh"
module lmf_device
  import lmf_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       NRST,
  lmf_link_if.dev         LINK,
  input  wire logic [7:0] SENSE,
  output logic      [8:0] ROW_SWITCH,
  output logic      [7:0] COLUMN_SINK,
  output logic      [8:0] ROW_PULL,
  output logic      [7:0] COL_PULL,
  output logic      [1:0] DETECT_MODE
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [10:0] raw;
  logic [10:0] s1_reg;
  logic [10:0] s2_reg;
  logic [10:0] s3_reg;
  logic [10:0] flt_reg;
  logic        scl_q_reg;
  logic        sda_q_reg;
  logic        pin_q_reg;
  logic        scl_f;
  logic        sda_f;
  logic        pin_f;
  logic [7:0]  sense_f;

  assign raw = {LINK.scl, LINK.sda, LINK.pdn_n, SENSE};

  // a change is taken only once two late stages agree
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      s1_reg    <= 11'h700;
      s2_reg    <= 11'h700;
      s3_reg    <= 11'h700;
      flt_reg   <= 11'h700;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      // idle level of the pin, so reset shows no false rising edge
      pin_q_reg <= 1'b1;
    end
    else
    begin
      s1_reg    <= raw;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      flt_reg   <= (~(s2_reg ^ s3_reg) & s2_reg) |
                   ((s2_reg ^ s3_reg) & flt_reg);
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
      pin_q_reg <= pin_f;
    end
  end

  assign scl_f   = flt_reg[10];
  assign sda_f   = flt_reg[9];
  assign pin_f   = flt_reg[8];
  assign sense_f = flt_reg[7:0];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] pwm_mem [0:71];
  logic [7:0] res_mem [0:8];
  logic [7:0] cap_mem [0:8];
  logic [7:0] cfg_reg;
  logic [7:0] gcl_reg;
  logic [7:0] pull_reg;
  logic       wr_en_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] ptr_reg;
  logic       soft_rst;

  assign soft_rst = wr_en_reg && ptr_reg == `LMF_A_RST &&
                    wr_data_reg == `LMF_RST_KEY;

  // reset and the key clear these registers, link writes load them
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cfg_reg  <= `LMF_REG_DEF;
      gcl_reg  <= `LMF_REG_DEF;
      pull_reg <= `LMF_REG_DEF;
      for (int i = 0; i < `LMF_PWM_DOTS; i++)
        pwm_mem[i] <= `LMF_REG_DEF;
    end
    else if (soft_rst)
    begin
      cfg_reg  <= `LMF_REG_DEF;
      gcl_reg  <= `LMF_REG_DEF;
      pull_reg <= `LMF_REG_DEF;
      for (int i = 0; i < `LMF_PWM_DOTS; i++)
        pwm_mem[i] <= `LMF_REG_DEF;
    end
    else if (wr_en_reg)
    begin
      if (ptr_reg >= `LMF_A_PWM0 && ptr_reg < `LMF_A_PWM0 + `LMF_PWM_DOTS)
        pwm_mem[7'(ptr_reg - `LMF_A_PWM0)] <= wr_data_reg;
      if (ptr_reg == `LMF_A_CFG)
        cfg_reg <= wr_data_reg;
      if (ptr_reg == `LMF_A_GCL)
        gcl_reg <= wr_data_reg;
      if (ptr_reg == `LMF_A_PULL)
        pull_reg <= wr_data_reg;
    end
  end

  function automatic logic [7:0] rd_val(input logic [7:0] a);
    logic [7:0] off;
    logic [3:0] rw;
    begin
      rd_val = `LMF_REG_DEF;
      off    = a - `LMF_A_RES0;
      rw     = off[4:1];
      if (a >= `LMF_A_PWM0 && a < `LMF_A_PWM0 + `LMF_PWM_DOTS)
        rd_val = pwm_mem[7'(a - `LMF_A_PWM0)];
      else if (a == `LMF_A_CFG)
        rd_val = cfg_reg;
      else if (a == `LMF_A_GCL)
        rd_val = gcl_reg;
      else if (a == `LMF_A_PULL)
        rd_val = pull_reg;
      else if (a >= `LMF_A_RES0 && a <= `LMF_A_RES_LAST)
        rd_val = off[0] ? {res_mem[rw][7:5], 5'h00}
                        : {1'b0, res_mem[rw][4:0], 2'h0};
    end
  endfunction

  // ----------------------------------------
  // serial register port
  // ----------------------------------------
  lmf_slv_t   st_reg;
  logic [3:0] bitc_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic       rw_reg;
  logic       oe_n_reg;
  logic       rise;
  logic       fall;
  logic [7:0] rd_byte;

  assign rise = scl_f && !scl_q_reg;
  assign fall = !scl_f && scl_q_reg;

  // a process, not an assign, so array contents are followed too
  always_comb
    rd_byte = rd_val(ptr_reg);

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_reg      <= LMF_S_IDLE;
      bitc_reg    <= 4'h0;
      sh_reg      <= 8'h00;
      tx_reg      <= 8'h00;
      rw_reg      <= 1'b0;
      oe_n_reg    <= 1'b1;
      ptr_reg     <= 8'h00;
      wr_en_reg   <= 1'b0;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      wr_en_reg <= 1'b0;
      // pin rising edge drops the transfer
      if (pin_f && !pin_q_reg)
      begin
        st_reg   <= LMF_S_IDLE;
        oe_n_reg <= 1'b1;
      end
      else if (scl_f && scl_q_reg && !sda_f && sda_q_reg)
      begin
        st_reg   <= LMF_S_ADDR;
        bitc_reg <= 4'h0;
        oe_n_reg <= 1'b1;
      end
      else if (scl_f && scl_q_reg && sda_f && !sda_q_reg)
      begin
        st_reg   <= LMF_S_IDLE;
        oe_n_reg <= 1'b1;
      end
      else if (st_reg != LMF_S_IDLE && st_reg != LMF_S_DONE)
      begin
        if (rise && bitc_reg < `LMF_BIT_ACK)
        begin
          sh_reg   <= {sh_reg[6:0], sda_f};
          bitc_reg <= bitc_reg + 4'h1;
        end
        else if (rise)
          bitc_reg <= `LMF_BIT_END;
        else if (fall && bitc_reg == `LMF_BIT_ACK)
        begin
          oe_n_reg <= 1'b0;
          unique case (st_reg)
            LMF_S_ADDR:
            begin
              rw_reg <= sh_reg[0];
              if (sh_reg[7:1] != `LMF_DEV_ADDR)
              begin
                st_reg   <= LMF_S_IDLE;
                oe_n_reg <= 1'b1;
              end
            end
            LMF_S_REG:
              ptr_reg <= sh_reg;
            LMF_S_WDATA:
            begin
              wr_en_reg   <= 1'b1;
              wr_data_reg <= sh_reg;
            end
            LMF_S_RDATA:
              oe_n_reg <= 1'b1;
            default:
              oe_n_reg <= 1'b1;
          endcase
        end
        else if (fall && bitc_reg == `LMF_BIT_END)
        begin
          bitc_reg <= 4'h0;
          oe_n_reg <= 1'b1;
          unique case (st_reg)
            LMF_S_ADDR:
              st_reg <= LMF_S_REG;
            LMF_S_REG:
            begin
              st_reg <= rw_reg ? LMF_S_RDATA : LMF_S_WDATA;
              if (rw_reg)
              begin
                oe_n_reg <= rd_byte[7];
                tx_reg   <= {rd_byte[6:0], 1'b0};
              end
            end
            default:
              st_reg <= LMF_S_DONE;
          endcase
        end
        else if (fall && st_reg == LMF_S_RDATA)
        begin
          oe_n_reg <= tx_reg[7];
          tx_reg   <= {tx_reg[6:0], 1'b0};
        end
      end
    end
  end

  assign LINK.sda_dev_o    = 1'b0;
  assign LINK.sda_dev_oe_n = oe_n_reg;

  // ----------------------------------------
  // scan and pwm
  // ----------------------------------------
  logic [7:0] step_reg;
  logic [7:0] duty_reg;
  logic [3:0] row_reg;
  logic       row_end;
  logic       scan_end;
  logic [7:0] sink_next;
  logic [8:0] row_next;
  logic       det_run_reg;

  always_comb
  begin
    row_end  = step_reg == 8'(`LMF_STEP_CYC - 1) && duty_reg == 8'hFF;
    scan_end = row_end && row_reg == 4'(`LMF_ROWS - 1);
    for (int c = 0; c < `LMF_COLS; c++)
      // duty compare, gated by both power-downs
      sink_next[c] = pin_f && cfg_reg[`LMF_CFG_SSD] &&
                     (det_run_reg ||
                      duty_reg < pwm_mem[{row_reg[3:0], 3'(c)}]);
    for (int r = 0; r < `LMF_ROWS; r++)
      row_next[r] = pin_f && row_reg == 4'(r);
  end

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      step_reg <= 8'h00;
      duty_reg <= 8'h00;
      row_reg  <= 4'h0;
    end
    else
    begin
      step_reg <= (step_reg == 8'(`LMF_STEP_CYC - 1)) ? 8'h00
                                                     : step_reg + 8'h01;
      if (step_reg == 8'(`LMF_STEP_CYC - 1))
        duty_reg <= duty_reg + 8'h01;
      if (scan_end)
        row_reg <= 4'h0;
      else if (row_end)
        row_reg <= row_reg + 4'h1;
    end
  end

  // pull only beside an off output
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      ROW_SWITCH  <= 9'h000;
      COLUMN_SINK <= 8'h00;
      ROW_PULL    <= 9'h000;
      COL_PULL    <= 8'h00;
    end
    else
    begin
      ROW_SWITCH  <= row_next;
      COLUMN_SINK <= sink_next;
      ROW_PULL    <= {9{pin_f && pull_reg[`LMF_PULL_ROW_HI:`LMF_PULL_ROW_LO]
                        != 4'h0}} & ~row_next;
      COL_PULL    <= {8{pin_f && pull_reg[`LMF_PULL_COL_HI:`LMF_PULL_COL_LO]
                        != 4'h0}} & ~sink_next;
    end
  end

  // ----------------------------------------
  // open and short detection
  // ----------------------------------------
  logic [1:0] os_sel;
  logic [1:0] os_q_reg;
  logic       scans_reg;
  logic       trig;

  assign os_sel = cfg_reg[`LMF_CFG_OS_HI:`LMF_CFG_OS_LO];
  // only a move away from 00 triggers
  assign trig = os_q_reg == `LMF_OS_NONE &&
                (os_sel == `LMF_OS_OPEN || os_sel == `LMF_OS_SHORT);

  // first scan end aligns, second copies out
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      os_q_reg    <= `LMF_OS_NONE;
      det_run_reg <= 1'b0;
      scans_reg   <= 1'b0;
      DETECT_MODE <= `LMF_OS_NONE;
      for (int i = 0; i < `LMF_ROWS; i++)
      begin
        res_mem[i] <= `LMF_REG_DEF;
        cap_mem[i] <= `LMF_REG_DEF;
      end
    end
    else
    begin
      os_q_reg    <= os_sel;
      DETECT_MODE <= det_run_reg ? os_sel : `LMF_OS_NONE;
      if (soft_rst)
      begin
        det_run_reg <= 1'b0;
        for (int i = 0; i < `LMF_ROWS; i++)
          res_mem[i] <= `LMF_REG_DEF;
      end
      else if (trig)
      begin
        det_run_reg <= 1'b1;
        scans_reg   <= 1'b0;
      end
      else if (det_run_reg && row_end)
      begin
        if (scans_reg)
          cap_mem[row_reg] <= sense_f;
        if (scan_end && !scans_reg)
          scans_reg <= 1'b1;
        else if (scan_end)
        begin
          det_run_reg <= 1'b0;
          for (int i = 0; i < `LMF_ROWS - 1; i++)
            res_mem[i] <= cap_mem[i];
          res_mem[`LMF_ROWS - 1] <= sense_f;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/lmf_host.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lmf_params.svh"
module lmf_host
  import lmf_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  lmf_link_if.host         LINK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ
);
  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic        acc;
  logic        wr;
  logic        busy_reg;
  logic [7:0]  rdata_reg;
  logic [1:0]  ist_reg;
  logic [1:0]  imsk_reg;
  logic        pdn_reg;
  logic [1:0]  ev_set;
  logic        go;
  logic        mapped;

  assign acc    = PSEL && PENABLE && PREADY;
  assign wr     = acc && PWRITE;
  assign go     = wr && PADDR == `LMF_H_CMD && !busy_reg;
  assign mapped = PADDR == `LMF_H_CMD || PADDR == `LMF_H_STAT ||
                  PADDR == `LMF_H_IST || PADDR == `LMF_H_IMSK ||
                  PADDR == `LMF_H_CTRL;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      PREADY   <= 1'b0;
      PRDATA   <= 32'h0000_0000;
      PSLVERR  <= 1'b0;
      ist_reg  <= 2'h0;
      imsk_reg <= 2'h0;
      pdn_reg  <= 1'b1;
      IRQ      <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
      PRDATA  <= 32'h0000_0000;
      if (PSEL && PENABLE && !PREADY && !PWRITE)
        unique case (PADDR)
          `LMF_H_STAT: PRDATA <= {16'h0000, rdata_reg, 7'h00, busy_reg};
          `LMF_H_IST:  PRDATA <= {30'h0000_0000, ist_reg};
          `LMF_H_IMSK: PRDATA <= {30'h0000_0000, imsk_reg};
          `LMF_H_CTRL: PRDATA <= {31'h0000_0000, pdn_reg};
          default:     PRDATA <= 32'h0000_0000;
        endcase
      // a new event wins over a clear in the same cycle
      ist_reg <= (ist_reg & ~((wr && PADDR == `LMF_H_IST) ?
                  PWDATA[1:0] : 2'h0)) | ev_set;
      if (wr && PADDR == `LMF_H_IMSK)
        imsk_reg <= PWDATA[1:0];
      if (wr && PADDR == `LMF_H_CTRL)
        pdn_reg <= PWDATA[0];
      IRQ <= |(ist_reg & imsk_reg);
    end
  end

  // ----------------------------------------
  // serial master
  // ----------------------------------------
  lmf_mst_t    st_reg;
  logic [7:0]  qc_reg;
  logic [1:0]  q_reg;
  logic [4:0]  bi_reg;
  logic [26:0] tx_reg;
  logic [26:0] rx_reg;
  logic        rd_reg;
  logic        scl_reg;
  logic        oe_n_reg;
  logic [2:0]  sy_reg;
  logic        sda_f_reg;
  logic        qtick;
  logic        nack;

  assign qtick = qc_reg == 8'(`LMF_QTR_CYC - 1);
  // a write must be acked three times, a read twice
  assign nack  = rx_reg[18] || rx_reg[9] || (!rd_reg && rx_reg[0]);
  assign ev_set = (st_reg == LMF_M_STOP && qtick && q_reg == 2'h3) ?
                  {nack, 1'b1} : 2'h0;

  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sy_reg    <= 3'h7;
      sda_f_reg <= 1'b1;
    end
    else
    begin
      sy_reg <= {sy_reg[1:0], LINK.sda};
      if (sy_reg[1] == sy_reg[2])
        sda_f_reg <= sy_reg[2];
    end
  end

  // setup order is left to software
  always_ff @(posedge CORE_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_reg    <= LMF_M_IDLE;
      qc_reg    <= 8'h00;
      q_reg     <= 2'h0;
      bi_reg    <= 5'h00;
      tx_reg    <= 27'h7FF_FFFF;
      rx_reg    <= 27'h000_0000;
      rd_reg    <= 1'b0;
      busy_reg  <= 1'b0;
      rdata_reg <= 8'h00;
      scl_reg   <= 1'b1;
      oe_n_reg  <= 1'b1;
    end
    else if (st_reg == LMF_M_IDLE)
    begin
      if (go)
      begin
        busy_reg <= 1'b1;
        rd_reg   <= PWDATA[`LMF_CMD_RD];
        tx_reg   <= {`LMF_DEV_ADDR, PWDATA[`LMF_CMD_RD], 1'b1,
                     PWDATA[7:0], 1'b1,
                     PWDATA[`LMF_CMD_RD] ? 8'hFF : PWDATA[15:8], 1'b1};
        st_reg   <= LMF_M_START;
        qc_reg   <= 8'h00;
        q_reg    <= 2'h0;
        bi_reg   <= 5'h00;
      end
    end
    else
    begin
      qc_reg <= qtick ? 8'h00 : qc_reg + 8'h01;
      if (qtick)
      begin
        q_reg <= q_reg + 2'h1;
        unique case (st_reg)
          LMF_M_START:
          begin
            if (q_reg == 2'h0)
              oe_n_reg <= 1'b0;
            if (q_reg == 2'h1)
              scl_reg <= 1'b0;
            if (q_reg == 2'h3)
              st_reg <= LMF_M_BITS;
          end
          LMF_M_BITS:
          begin
            if (q_reg == 2'h0)
              oe_n_reg <= tx_reg[26];
            if (q_reg == 2'h1)
              scl_reg <= 1'b1;
            if (q_reg == 2'h2)
              rx_reg <= {rx_reg[25:0], sda_f_reg};
            if (q_reg == 2'h3)
            begin
              scl_reg <= 1'b0;
              tx_reg  <= {tx_reg[25:0], 1'b1};
              bi_reg  <= bi_reg + 5'h01;
              if (bi_reg == 5'(`LMF_FRAME_BITS - 1))
                st_reg <= LMF_M_STOP;
            end
          end
          default:
          begin
            if (q_reg == 2'h0)
              oe_n_reg <= 1'b0;
            if (q_reg == 2'h1)
              scl_reg <= 1'b1;
            if (q_reg == 2'h2)
              oe_n_reg <= 1'b1;
            if (q_reg == 2'h3)
            begin
              st_reg    <= LMF_M_IDLE;
              busy_reg  <= 1'b0;
              rdata_reg <= rx_reg[8:1];
            end
          end
        endcase
      end
    end
  end

  assign LINK.scl           = scl_reg;
  assign LINK.sda_host_o    = 1'b0;
  assign LINK.sda_host_oe_n = oe_n_reg;
  assign LINK.pdn_n         = pdn_reg;
endmodule
`default_nettype wire

// *** testbench/lmf_link_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module lmf_link_asserts
(
  input wire logic       CORE_CLK,
  input wire logic       NRST,
  input wire logic       scl,
  input wire logic       pdn_n,
  input wire logic       sda_dev_oe_n,
  input wire logic [8:0] ROW_SWITCH,
  input wire logic [7:0] COLUMN_SINK,
  input wire logic [8:0] ROW_PULL,
  input wire logic [7:0] COL_PULL,
  input wire logic [1:0] DETECT_MODE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // ----------------------------------------
  // matrix outputs
  // ----------------------------------------
  row_onehot_a: assert property ($onehot0(ROW_SWITCH))
    else $error("more than one row switched on");
  row_pull_off_a: assert property ((ROW_PULL & ROW_SWITCH) == 9'h000)
    else $error("row pull on a driven row");
  col_pull_off_a: assert property ((COL_PULL & COLUMN_SINK) == 8'h00)
    else $error("column pull on a sinking column");
  // filter plus register stage fits well inside eight cycles
  pin_blank_a: assert property ((!pdn_n) [*8] |->
    (COLUMN_SINK == 8'h00 && ROW_SWITCH == 9'h000 && ROW_PULL == 9'h000))
    else $error("outputs active in pin power-down");
  mode_legal_a: assert property (DETECT_MODE != 2'b11)
    else $error("illegal detect mode");
  mode_steady_a: assert property ($rose(|DETECT_MODE) |=>
    $stable(DETECT_MODE) [*8])
    else $error("detect mode glitched");
  // ----------------------------------------
  // serial port
  // ----------------------------------------
  ack_on_low_a: assert property ($fell(sda_dev_oe_n) |-> !scl)
    else $error("device drove data while clock high");
  port_reset_a: assert property ($rose(pdn_n) |-> ##[1:8] sda_dev_oe_n)
    else $error("serial port not released after pin rise");
  detect_c: cover property ($rose(|DETECT_MODE));
  pin_low_c: cover property ($fell(pdn_n));
  dev_ack_c: cover property ($fell(sda_dev_oe_n));
endmodule
`default_nettype wire

// *** testbench/led_matrix_fault_detect_shutdown_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "lmf_params.svh"
module led_matrix_fault_detect_shutdown_tb_top
  import lmf_pkg::*;
;
  logic        CORE_CLK = 1'b0;
  logic        NRST;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        IRQ;
  logic [7:0]  SENSE;
  logic [8:0]  ROW_SWITCH;
  logic [8:0]  ROW_PULL;
  logic [7:0]  COLUMN_SINK;
  logic [7:0]  COL_PULL;
  logic [1:0]  DETECT_MODE;
  logic [31:0] q;
  logic        e;
  logic [7:0]  b;
  int          fail_count = 0;
  int          total_checks = 0;

  always #5 CORE_CLK = ~CORE_CLK;

  lmf_link_if lmf_link_if_inst ();
  lmf_device lmf_device_inst (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .LINK(lmf_link_if_inst), .SENSE(SENSE), .ROW_SWITCH(ROW_SWITCH),
    .COLUMN_SINK(COLUMN_SINK), .ROW_PULL(ROW_PULL), .COL_PULL(COL_PULL),
    .DETECT_MODE(DETECT_MODE));
  lmf_host lmf_host_inst (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .LINK(lmf_link_if_inst), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ));
  lmf_link_asserts lmf_link_asserts_inst (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .scl(lmf_link_if_inst.scl), .pdn_n(lmf_link_if_inst.pdn_n),
    .sda_dev_oe_n(lmf_link_if_inst.sda_dev_oe_n), .ROW_SWITCH(ROW_SWITCH),
    .COLUMN_SINK(COLUMN_SINK), .ROW_PULL(ROW_PULL), .COL_PULL(COL_PULL),
    .DETECT_MODE(DETECT_MODE));

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task stop_test;
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task bail(input string what);
    fail_count++;
    $display("Error %s expected answer seen timeout", what);
    stop_test();
  endtask

  // one setup cycle, then hold the access until pready is sampled
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rq, output logic re);
    int n;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1)
      bail("pready");
    rq = PRDATA;
    re = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // a whole link frame: command, then poll busy with a bound
  task dev(input logic rd, input logic [7:0] r, input logic [7:0] d,
           output logic [7:0] dq);
    logic [31:0] s;
    logic        se;
    int          n;
    apb(1'b1, `LMF_H_CMD, {15'h0000, rd, d, r}, s, se);
    n = 0;
    do
    begin
      apb(1'b0, `LMF_H_STAT, 32'h0000_0000, s, se);
      n++;
    end
    while (s[0] !== 1'b0 && n < 2000);
    if (s[0] !== 1'b0)
      bail("busy");
    dq = s[15:8];
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    NRST = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    SENSE = 8'hA5;
    repeat (4) @(posedge CORE_CLK);
    NRST <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    apb(1'b1, `LMF_H_IMSK, 32'h0000_0001, q, e);
    apb(1'b0, 8'h40, 32'h0000_0000, q, e);
    chk("unmapped err", 32'h0000_0001, {31'h0000_0000, e});
    chk("unmapped data", 32'h0000_0000, q);
    dev(1'b1, `LMF_A_CFG, 8'h00, b);
    chk("config default", 32'h0000_0000, {24'h00_0000, b});
    chk("irq raised", 32'h0000_0001, {31'h0000_0000, IRQ});
    apb(1'b1, `LMF_H_IST, 32'h0000_0001, q, e);
    repeat (2) @(posedge CORE_CLK);
    chk("irq cleared", 32'h0000_0000, {31'h0000_0000, IRQ});
    chk("soft blank", 32'h0000_0000, {24'h00_0000, COLUMN_SINK});
    dev(1'b0, `LMF_A_PULL, 8'hFF, b);
    chk("row pull", 32'h0000_01FF, {23'h0, ROW_PULL | ROW_SWITCH});
    chk("col pull", 32'h0000_00FF, {24'h0, COL_PULL | COLUMN_SINK});
    dev(1'b0, `LMF_A_PWM0, 8'h04, b);
    dev(1'b1, `LMF_A_PWM0, 8'h00, b);
    chk("duty", 32'h0000_0004, {24'h00_0000, b});
    dev(1'b0, `LMF_A_GCL, 8'h0F, b);
    dev(1'b0, `LMF_A_PULL, 8'h00, b);
    dev(1'b0, `LMF_A_CFG, 8'h03, b);
    repeat (1000) @(posedge CORE_CLK);
    chk("detect sinks", 32'h0000_00FF, {24'h00_0000, COLUMN_SINK});
    // select stays at 01 while the soft power-down bit drops
    dev(1'b0, `LMF_A_CFG, 8'h02, b);
    chk("soft blank run", 32'h0000_0000, {24'h00_0000, COLUMN_SINK});
    repeat (47200) @(posedge CORE_CLK);
    dev(1'b1, `LMF_A_RES0, 8'h00, b);
    chk("result odd", 32'h0000_0014, {24'h00_0000, b});
    dev(1'b1, `LMF_A_RES_LAST, 8'h00, b);
    chk("result even", 32'h0000_00A0, {24'h00_0000, b});
    SENSE <= 8'h00;
    dev(1'b0, `LMF_A_CFG, 8'h03, b);
    dev(1'b1, `LMF_A_RES0, 8'h00, b);
    chk("result held", 32'h0000_0014, {24'h00_0000, b});
    apb(1'b1, `LMF_H_CTRL, 32'h0000_0000, q, e);
    repeat (10) @(posedge CORE_CLK);
    chk("pin low", 32'h0000_0000, {31'h0, lmf_link_if_inst.pdn_n});
    chk("pin blank", 32'h0000_0000, {15'h0, ROW_SWITCH, COLUMN_SINK});
    dev(1'b1, `LMF_A_GCL, 8'h00, b);
    chk("current kept", 32'h0000_000F, {24'h00_0000, b});
    apb(1'b1, `LMF_H_CTRL, 32'h0000_0001, q, e);
    // keep the link quiet around the pin edge
    repeat (1000) @(posedge CORE_CLK);
    dev(1'b1, `LMF_A_RES0, 8'h00, b);
    chk("result kept", 32'h0000_0014, {24'h00_0000, b});
    dev(1'b0, `LMF_A_RST, `LMF_RST_KEY, b);
    dev(1'b1, `LMF_A_GCL, 8'h00, b);
    chk("current reset", 32'h0000_0000, {24'h00_0000, b});
    dev(1'b1, `LMF_A_RES0, 8'h00, b);
    chk("result reset", 32'h0000_0000, {24'h00_0000, b});
    stop_test();
  end
endmodule
`default_nettype wire
